// ===== logic/spr_pkg.sv
// Package for the serializer identity, power and reset register bank.
// Assumes a host-side register access port driven by a local slave engine.
package spr_pkg;

    // Register offsets
    localparam logic [7:0] OFS_SLAVE_ADDRESS_SELECT = 8'h00;
    localparam logic [7:0] OFS_POWER_AND_RESET_CONTROL = 8'h01;
    localparam logic [7:0] OFS_RESERVED_TWO = 8'h02;
    localparam int NUM_REGS = 3;

    // Field positions
    localparam int ADDR_SRC_BIT = 0;
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 1;
    localparam int DRIVE_BIT = 6;
    localparam int AUTO_DET_BIT = 5;
    localparam int LEVEL_BIT = 4;
    localparam int PWDN_BIT = 3;
    localparam int PART_RST_BIT = 1;
    localparam int FULL_RST_BIT = 0;

    // Reset values and power register write mask
    localparam logic [6:0] ADDR_RESET = 7'h58;
    localparam logic [7:0] SEL_RESET = 8'hB0;
    localparam logic [7:0] PWR_RESET = 8'h30;
    localparam logic [7:0] PWR_WMASK = 8'h78;
    localparam logic [7:0] ZERO8 = 8'h00;

    // Strap decode table
    localparam logic [1:0] STRAP_0 = 2'h0;
    localparam logic [1:0] STRAP_1 = 2'h1;
    localparam logic [1:0] STRAP_2 = 2'h2;
    localparam logic [6:0] STRAP_ADDR_0 = 7'h58;
    localparam logic [6:0] STRAP_ADDR_1 = 7'h59;
    localparam logic [6:0] STRAP_ADDR_2 = 7'h5A;
    localparam logic [6:0] STRAP_ADDR_3 = 7'h5D;

    // Register access request from the slave engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic local_acc;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spr_req_t;

    // Control outputs to the rest of the device
    typedef struct packed {
        logic drive_high;
        logic auto_detect;
        logic level_3v3;
        logic analog_pd;
    } spr_ctl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PART = 3'b010,
        ST_FULL = 3'b100
    } spr_state_t;

endpackage

// ===== logic/spr_regs.sv
// Identity, power and reset register bank of the serializer.
// Assumes a local slave engine presents one-cycle read/write strobes.
// Contract
// - Address register bits 7:1 hold programmed address, reset 0x58.
// - Strap address is never copied into the programmed address field.
// - Select bit 0 picks strap address (0) or programmed address (1).
// - Bit 6 of power register selects high drive; resets to 0.
// - Bit 5 enables automatic supply detection; resets to 1.
// - Bit 4 selects 3.3 V when 1, 1.8 V when 0; resets 1.
// - Bit 3 powers down analog; only local accesses may set it.
// - Bit 1 resets logic but keeps registers and address; self-clears.
// - Bit 0 resets logic and all registers to default; self-clears.
// - Read-to-clear fields return value then clear on read.
// - Latched fields hold captured event until read.
// - Strap fields load from sampled strap pins at startup.
// - Self-clearing bits act on written 1 then return to 0.
// - Register map is reached through the integrated slave port.
`timescale 1ns/10ps
module spr_regs (
    mclk,
    resetn,
    req,
    address_strap_pin,
    rdata,
    rvalid,
    active_slave_address,
    ctl,
    logic_reset,
    hold_slave_state
);
    input wire logic mclk;
    input wire logic resetn;
    input wire spr_pkg::spr_req_t req;
    input wire logic [1:0] address_strap_pin;
    output logic [7:0] rdata;
    output logic rvalid;
    output logic [6:0] active_slave_address;
    output spr_pkg::spr_ctl_t ctl;
    output logic logic_reset;
    output logic hold_slave_state;

    logic [1:0] strap_s;
    logic [7:0] sel_r, sel_nxt;
    logic [7:0] pwr_r, pwr_nxt;
    logic [6:0] strap_addr_r, strap_addr_nxt;
    logic strap_done_r, strap_done_nxt;
    logic [7:0] rdata_nxt;
    logic rvalid_nxt;
    logic [6:0] act_nxt;
    spr_pkg::spr_ctl_t ctl_nxt;
    logic logic_reset_nxt;
    logic hold_nxt;
    spr_pkg::spr_state_t state_r, state_nxt;
    logic [6:0] strap_dec;
    logic [1:0] strap_wait_r, strap_wait_nxt;

    // ===========================================
    // Strap pin capture
    spr_sync #(
        .W(2)
    ) u_strap_sync (
        .mclk(mclk),
        .resetn(resetn),
        .din(address_strap_pin),
        .dout(strap_s)
    );

    // Strap level to address decode
    always_comb
    begin
        case (strap_s)
            spr_pkg::STRAP_0: strap_dec = spr_pkg::STRAP_ADDR_0;
            spr_pkg::STRAP_1: strap_dec = spr_pkg::STRAP_ADDR_1;
            spr_pkg::STRAP_2: strap_dec = spr_pkg::STRAP_ADDR_2;
            default: strap_dec = spr_pkg::STRAP_ADDR_3;
        endcase
    end

    // ===========================================
    // Next register values and reset sequencing
    always_comb
    begin
        sel_nxt = sel_r;
        pwr_nxt = pwr_r;
        state_nxt = spr_pkg::ST_IDLE;
        logic_reset_nxt = 1'b0;
        hold_nxt = 1'b0;
        // Register writes from the slave port
        if (req.wr)
        begin
            case (req.addr)
                spr_pkg::OFS_SLAVE_ADDRESS_SELECT:
                    sel_nxt = req.wdata;
                spr_pkg::OFS_POWER_AND_RESET_CONTROL:
                begin
                    pwr_nxt = req.wdata & spr_pkg::PWR_WMASK;
                    if (!req.local_acc && !pwr_r[spr_pkg::PWDN_BIT])
                        pwr_nxt[spr_pkg::PWDN_BIT] = 1'b0;
                    if (req.wdata[spr_pkg::FULL_RST_BIT])
                        state_nxt = spr_pkg::ST_FULL;
                    else if (req.wdata[spr_pkg::PART_RST_BIT])
                        state_nxt = spr_pkg::ST_PART;
                end
                default: ;
            endcase
        end
        // Reset actions; the trigger bits never store, so they read back 0
        case (state_r)
            spr_pkg::ST_PART:
            begin
                logic_reset_nxt = 1'b1;
                hold_nxt = 1'b1;
            end
            spr_pkg::ST_FULL:
            begin
                logic_reset_nxt = 1'b1;
                sel_nxt = spr_pkg::SEL_RESET;
                pwr_nxt = spr_pkg::PWR_RESET;
            end
            default: ;
        endcase
        // Answer address and control outputs
        act_nxt = sel_r[spr_pkg::ADDR_SRC_BIT] ?
            sel_r[spr_pkg::ADDR_MSB:spr_pkg::ADDR_LSB] : strap_addr_r;
        ctl_nxt.drive_high = pwr_r[spr_pkg::DRIVE_BIT];
        ctl_nxt.auto_detect = pwr_r[spr_pkg::AUTO_DET_BIT];
        ctl_nxt.level_3v3 = pwr_r[spr_pkg::LEVEL_BIT];
        ctl_nxt.analog_pd = pwr_r[spr_pkg::PWDN_BIT];
    end

    // Control registers, sequencer and answer outputs
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            sel_r <= spr_pkg::SEL_RESET;
            pwr_r <= spr_pkg::PWR_RESET;
            state_r <= spr_pkg::ST_IDLE;
            active_slave_address <= spr_pkg::ADDR_RESET;
            ctl <= '0;
            logic_reset <= 1'b0;
            hold_slave_state <= 1'b0;
        end
        else
        begin
            sel_r <= sel_nxt;
            pwr_r <= pwr_nxt;
            state_r <= state_nxt;
            active_slave_address <= act_nxt;
            ctl <= ctl_nxt;
            logic_reset <= logic_reset_nxt;
            hold_slave_state <= hold_nxt;
        end
    end

    // ===========================================
    // Strap capture, held off until the synchroniser has flushed its reset zeros
    always_comb
    begin
        strap_wait_nxt = {strap_wait_r[0], 1'b1};
        strap_addr_nxt = strap_addr_r;
        strap_done_nxt = strap_done_r;
        // A full reset re-arms the capture from the settled strap level
        if (state_r == spr_pkg::ST_FULL)
        begin
            strap_done_nxt = 1'b0;
        end
        else if (!strap_done_r && (&strap_wait_r))
        begin
            strap_addr_nxt = strap_dec;
            strap_done_nxt = 1'b1;
        end
    end

    // Strap registers
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            strap_wait_r <= '0;
            strap_addr_r <= spr_pkg::ADDR_RESET;
            strap_done_r <= 1'b0;
        end
        else
        begin
            strap_wait_r <= strap_wait_nxt;
            strap_addr_r <= strap_addr_nxt;
            strap_done_r <= strap_done_nxt;
        end
    end

    // ===========================================
    // Read path; no read-to-clear or latched fields live in this bank
    always_comb
    begin
        rdata_nxt = rdata;
        rvalid_nxt = 1'b0;
        if (req.rd)
        begin
            rvalid_nxt = 1'b1;
            case (req.addr)
                spr_pkg::OFS_SLAVE_ADDRESS_SELECT: rdata_nxt = sel_r;
                spr_pkg::OFS_POWER_AND_RESET_CONTROL: rdata_nxt = pwr_r;
                default: rdata_nxt = spr_pkg::ZERO8;
            endcase
        end
    end

    // Read answer registers; data holds until the next read
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            rdata <= spr_pkg::ZERO8;
            rvalid <= 1'b0;
        end
        else
        begin
            rdata <= rdata_nxt;
            rvalid <= rvalid_nxt;
        end
    end
endmodule

// ===== logic/spr_sync.sv
// Two-stage synchroniser for a multi-bit level from a pin.
// Assumes the bits are static straps, so skew between bits is harmless.
`timescale 1ns/10ps
module spr_sync #(
    parameter int W = 2
) (
    mclk,
    resetn,
    din,
    dout
);
    input wire logic mclk;
    input wire logic resetn;
    input wire logic [W-1:0] din;
    output logic [W-1:0] dout;

    logic [W-1:0] meta_r;

    // ===========================================
    // Synchroniser stages
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            meta_r <= '0;
            dout <= '0;
        end
        else
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

// ===== sim/spr_host.sv
// Local host model issuing register accesses.
// Assumes the bench calls its tasks after reset.
`timescale 1ns/10ps
module spr_host (
    input wire logic mclk,
    output spr_pkg::spr_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    // ====================
    // Idle request, released fields show inverted values
    initial req = '{1'b0, 1'b0, 1'b0, 8'hFF, 8'hFF};
    task automatic rel;
        req <= '{1'b0, 1'b0, ~req.local_acc, ~req.addr, ~req.wdata};
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic l);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, l, a, v};
        @(posedge mclk);
        rel();
    endtask
    // Read, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b0, 1'b1, 1'b1, a, 8'h00};
        @(posedge mclk);
        rel();
        #1;
        d = (rvalid === 1'b1) ? rdata : 8'hXX;
    endtask
endmodule

// ===== sim/spr_regs_props.sv
// Checker for the register bank outputs.
// Assumes it is bound into every spr_regs instance.
`timescale 1ns/10ps
module spr_regs_props (
    input wire logic mclk,
    input wire logic resetn,
    input wire spr_pkg::spr_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic [6:0] active_slave_address,
    input wire spr_pkg::spr_ctl_t ctl,
    input wire logic logic_reset,
    input wire logic hold_slave_state
);
    // ====================
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_pwr_wr;
        !req.wr ##1 req.wr && req.local_acc && req.addr == 8'h01 && req.wdata[1:0] == 2'h0
            ##1 !req.wr;
    endsequence
    sequence s_sel_wr;
        !req.wr ##1 req.wr && req.addr == 8'h00 && req.wdata[0] ##1 !req.wr;
    endsequence
    property p_rv; req.rd |=> rvalid; endproperty
    property p_rvn; !req.rd |=> !rvalid; endproperty
    property p_ctl; s_pwr_wr |-> ##1 ctl == $past(req.wdata[6:3], 2); endproperty
    property p_rmt;
        !req.wr ##1 req.wr && !req.local_acc && req.addr == 8'h01 && !ctl.analog_pd
            ##1 !req.wr |-> ##1 !ctl.analog_pd;
    endproperty
    property p_sel; s_sel_wr |-> ##1 active_slave_address == $past(req.wdata[7:1], 2); endproperty
    property p_part;
        req.wr && req.addr == 8'h01 && req.wdata[1:0] == 2'h2
            |-> ##2 logic_reset && hold_slave_state;
    endproperty
    property p_full; req.wr && req.addr == 8'h01 && req.wdata[0] |-> ##2 logic_reset && !hold_slave_state; endproperty
    property p_fctl; req.wr && req.addr == 8'h01 && req.wdata[0] |-> ##3 ctl == 4'h6; endproperty
    property p_sc; logic_reset |=> !logic_reset; endproperty
    property p_rsv; req.rd && req.addr == 8'h02 |=> rdata == 8'h00; endproperty
    a_rv: assert property (p_rv) else $error("rvalid timing wrong");
    a_rvn: assert property (p_rvn) else $error("rvalid without read");
    a_ctl: assert property (p_ctl) else $error("ctl not from write");
    a_rmt: assert property (p_rmt) else $error("remote set power down");
    a_sel: assert property (p_sel) else $error("programmed address wrong");
    a_part: assert property (p_part) else $error("partial reset wrong");
    a_full: assert property (p_full) else $error("full reset wrong");
    a_fctl: assert property (p_fctl) else $error("ctl not restored");
    a_sc: assert property (p_sc) else $error("reset not one pulse");
    a_rsv: assert property (p_rsv) else $error("reserved read not zero");
endmodule
bind spr_regs spr_regs_props spr_regs_props_i (.mclk(mclk), .resetn(resetn), .req(req),
    .rdata(rdata), .rvalid(rvalid), .active_slave_address(active_slave_address),
    .ctl(ctl), .logic_reset(logic_reset), .hold_slave_state(hold_slave_state));

// ===== sim/spr_regs_tb_top.sv
// Testbench for the register bank.
// Assumes the host model and checker are compiled first.
`timescale 1ns/10ps
module spr_regs_tb_top;
    logic mclk;
    logic resetn;
    logic [1:0] strap;
    spr_pkg::spr_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    logic [6:0] act;
    spr_pkg::spr_ctl_t ctl;
    logic lr;
    logic hold;
    logic [7:0] d;
    int n_errors;
    int checks;
    spr_regs spr_regs_i (.mclk(mclk), .resetn(resetn), .req(req), .address_strap_pin(strap),
        .rdata(rdata), .rvalid(rvalid), .active_slave_address(act), .ctl(ctl),
        .logic_reset(lr), .hold_slave_state(hold));
    spr_host spr_host_i (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid));
    // ====================
    // Clock and watchdog
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        #250000;
        n_errors++;
        results();
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        spr_host_i.rd(a, d);
        chk(d, e);
    endtask
    // Reset write, counts both pulse outputs
    task automatic pulses(input logic [7:0] v, input logic [7:0] e);
        logic [3:0] nl;
        logic [3:0] nh;
        nl = 4'h0;
        nh = 4'h0;
        spr_host_i.wr(8'h01, v, 1'b1);
        repeat (6)
        begin
            @(posedge mclk);
            #1;
            nl = nl + {3'h0, lr};
            nh = nh + {3'h0, hold};
        end
        chk({nl, nh}, e);
    endtask
    task automatic t_pwr;
        spr_host_i.wr(8'h01, 8'hFC, 1'b1);
        rdchk(8'h01, 8'h78);
        chk({4'h0, ctl}, 8'h0F);
        spr_host_i.wr(8'h01, 8'h00, 1'b0);
        spr_host_i.wr(8'h01, 8'h08, 1'b0);
        rdchk(8'h01, 8'h00);
        spr_host_i.wr(8'h02, 8'hFF, 1'b1);
        rdchk(8'h02, 8'h00);
    endtask
    task automatic t_rst;
        spr_host_i.wr(8'h00, 8'h8B, 1'b1);
        pulses(8'h0A, 8'h11);
        rdchk(8'h01, 8'h08);
        chk({1'b0, act}, 8'h45);
        pulses(8'h03, 8'h10);
        rdchk(8'h00, 8'hB0);
        rdchk(8'h01, 8'h30);
        chk({1'b0, act}, 8'h5D);
        spr_host_i.wr(8'h00, 8'h8A, 1'b1);
        rdchk(8'h00, 8'h8A);
        chk({1'b0, act}, 8'h5D);
    endtask
    // Reset in mid-run with another strap level
    task automatic t_boot;
        @(posedge mclk);
        resetn <= 1'b0;
        strap <= 2'h1;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        chk({1'b0, act}, 8'h59);
        chk({4'h0, ctl}, 8'h06);
        rdchk(8'h00, 8'hB0);
        rdchk(8'h01, 8'h30);
    endtask
    task results;
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        resetn = 1'b0;
        strap = 2'h3;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        rdchk(8'h00, 8'hB0);
        rdchk(8'h01, 8'h30);
        chk({4'h0, ctl}, 8'h06);
        chk({1'b0, act}, 8'h5D);
        t_pwr();
        t_rst();
        t_boot();
        results();
    end
endmodule
